/* include/bbfh_params.svh */
// Timing counts, bus widths and command codes for the boot-block flash host.
// Included by the package and the host modules; holds definitions only.
`ifndef BBFH_PARAMS_SVH
`define BBFH_PARAMS_SVH

`define BBFH_CLK_PERIOD_NS   10
`define BBFH_RST_LOW_NS      500
`define BBFH_RST_LOW_CYC     ((`BBFH_RST_LOW_NS + `BBFH_CLK_PERIOD_NS - 1) / `BBFH_CLK_PERIOD_NS)
`define BBFH_RST_READY_NS    50
`define BBFH_RST_READY_CYC   ((`BBFH_RST_READY_NS + `BBFH_CLK_PERIOD_NS - 1) / `BBFH_CLK_PERIOD_NS)
`define BBFH_RST_BUSY_US     10
`define BBFH_RST_BUSY_CYC    ((`BBFH_RST_BUSY_US * 1000 + `BBFH_CLK_PERIOD_NS - 1) / `BBFH_CLK_PERIOD_NS)
`define BBFH_STROBE_CYC      8
`define BBFH_ADDR_W          18
`define BBFH_DATA_W          16
`define BBFH_UNLOCK_A1       18'h05555
`define BBFH_UNLOCK_D1       8'haa
`define BBFH_UNLOCK_A2       18'h02aaa
`define BBFH_UNLOCK_D2       8'h55
`define BBFH_CMD_READ        8'hf0
`define BBFH_CMD_AUTOSEL     8'h90
`define BBFH_CMD_PROGRAM     8'ha0
`define BBFH_CMD_ERASE_SETUP 8'h80
`define BBFH_CMD_BLK_ERASE   8'h30
`define BBFH_CMD_CHIP_ERASE  8'h10
`define BBFH_CMD_SUSPEND     8'hb0
`define BBFH_CMD_RESUME      8'h30
`define BBFH_BIT_POLL        7
`define BBFH_BIT_TOGGLE      6
`define BBFH_BIT_ERROR       5
`define BBFH_BIT_ETIMER      3
`define BBFH_BIT_TOGGLE2     2

`endif

/* include/bbfh_pkg.sv */
// Types shared by the boot-block flash host modules.
// Assumes bbfh_params.svh sits on the include path.
`include "bbfh_params.svh"
package bbfh_pkg;

	// Operations the user may request.
	typedef enum logic [2:0] {
		BBFH_OP_READ,
		BBFH_OP_PROGRAM,
		BBFH_OP_BLK_ERASE,
		BBFH_OP_CHIP_ERASE,
		BBFH_OP_SUSPEND,
		BBFH_OP_RESUME,
		BBFH_OP_RESET_CMD,
		BBFH_OP_HW_RESET
	} bbfh_op_t;

	// One user request.
	typedef struct packed {
		bbfh_op_t                 op;
		logic [`BBFH_ADDR_W-1:0]  addr;
		logic                     addr_lsb;
		logic [`BBFH_DATA_W-1:0]  data;
	} bbfh_req_t;

	// One bus cycle handed to the strobe engine.
	typedef struct packed {
		logic                     is_write;
		logic [`BBFH_ADDR_W-1:0]  addr;
		logic                     addr_lsb;
		logic [`BBFH_DATA_W-1:0]  data;
	} bbfh_cyc_t;

	// Decoded status bits of a status read.
	typedef struct packed {
		logic poll;
		logic toggle;
		logic error;
		logic erase_timer;
		logic toggle2;
	} bbfh_stat_t;

endpackage

/* hw/bbfh_strobe.sv */
// Single bus-cycle engine: drives chip enable, write and output enable and the data pins.
// Assumes a caller that waits for o_done before issuing the next cycle; data pins arrive unsynchronised.
`timescale 1ns/1ns
`include "bbfh_params.svh"
module bbfh_strobe
	import bbfh_pkg::*;
#(
	parameter int STROBE_CYC = `BBFH_STROBE_CYC
) (
	// Clock and reset.
	input  wire logic                    i_clk,
	input  wire logic                    i_rst,
	// Cycle request.
	input  wire logic                    i_start,
	input  wire bbfh_cyc_t               i_cyc,
	input  wire logic                    i_byte_mode,
	output logic                         o_done,
	output logic [`BBFH_DATA_W-1:0]      o_rdata,
	// Device pins.
	output logic                         o_ce_n,
	output logic                         o_we_n,
	output logic                         o_oe_n,
	output logic [`BBFH_ADDR_W-1:0]      o_addr,
	output logic [`BBFH_DATA_W-1:0]      o_dq,
	output logic [`BBFH_DATA_W-1:0]      o_dq_oe_n,
	input  wire logic [`BBFH_DATA_W-1:0] i_dq
);

	typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} bbfh_sst_t;

	bbfh_sst_t               st_reg, st_next;
	logic [7:0]              cnt_reg, cnt_next;
	logic                    wr_reg, wr_next;
	logic                    ce_reg, ce_next, we_reg, we_next, oe_reg, oe_next;
	logic [`BBFH_ADDR_W-1:0] a_reg, a_next;
	logic [`BBFH_DATA_W-1:0] d_reg, d_next, doe_reg, doe_next, rd_reg, rd_next;
	logic                    done_reg, done_next;
	logic [`BBFH_DATA_W-1:0] sync1_reg, sync2_reg;

	// Two flops on the data pins before anything samples them.
	always_ff @(posedge i_clk) begin
		sync1_reg <= i_dq;
		sync2_reg <= sync1_reg;
	end

	// Address settles before the falling strobe, data stays past the rising one.
	always_comb begin
		st_next = st_reg;
		cnt_next = cnt_reg;
		wr_next = wr_reg;
		ce_next = ce_reg;
		we_next = we_reg;
		oe_next = oe_reg;
		a_next = a_reg;
		d_next = d_reg;
		doe_next = doe_reg;
		rd_next = rd_reg;
		done_next = 1'b0;
		case (st_reg)
			ST_IDLE: begin
				if (i_start) begin
					wr_next = i_cyc.is_write;
					a_next = i_cyc.addr;
					d_next = i_cyc.data;
					// Byte mode: the top data pin carries the low address bit, bits 8..14 are left floating.
					if (i_byte_mode) begin
						d_next[15] = i_cyc.addr_lsb;
						doe_next = {1'b0, 7'h7f, {8{~i_cyc.is_write}}};
					end else begin
						doe_next = {16{~i_cyc.is_write}};
					end
					cnt_next = 8'h00;
					st_next = ST_SETUP;
				end
			end
			ST_SETUP: begin
				ce_next = 1'b0;
				we_next = ~wr_reg; // RULE_23
				oe_next = wr_reg; // RULE_24
				st_next = ST_STROBE;
			end
			ST_STROBE: begin
				cnt_next = cnt_reg + 8'h01;
				if (cnt_reg == 8'(STROBE_CYC - 1)) begin
					rd_next = sync2_reg;
					we_next = 1'b1; // RULE_12
					oe_next = 1'b1;
					ce_next = 1'b1;
					st_next = ST_HOLD;
				end
			end
			ST_HOLD: begin
				doe_next = 16'hffff;
				done_next = 1'b1;
				st_next = ST_IDLE;
			end
			default: st_next = ST_IDLE;
		endcase
	end

	// State registers; pins return to idle on reset.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_reg <= ST_IDLE;
			cnt_reg <= 8'h00;
			wr_reg <= 1'b0;
			ce_reg <= 1'b1;
			we_reg <= 1'b1;
			oe_reg <= 1'b1;
			a_reg <= '0;
			d_reg <= '0;
			doe_reg <= 16'hffff;
			rd_reg <= '0;
			done_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			wr_reg <= wr_next;
			ce_reg <= ce_next;
			we_reg <= we_next;
			oe_reg <= oe_next;
			a_reg <= a_next;
			d_reg <= d_next;
			doe_reg <= doe_next;
			rd_reg <= rd_next;
			done_reg <= done_next;
		end
	end

	assign o_done = done_reg;
	assign o_rdata = rd_reg;
	assign o_ce_n = ce_reg;
	assign o_we_n = we_reg;
	assign o_oe_n = oe_reg;
	assign o_addr = a_reg;
	assign o_dq = d_reg;
	assign o_dq_oe_n = doe_reg;

endmodule

/* hw/bbfh_host.sv */
// Host controller for a parallel boot-block flash: turns user requests into coded write sequences.
// Assumes the device pins are wired to the flash directly; the ready/busy and data pins are asynchronous.
//
// Operation
// RULE_01: Program needs four write cycles, erase six, before anything starts.
// RULE_02: Cycles one, two, four, five carry the same fixed unlock pattern.
// RULE_03: Bad command or sequence returns the device to array read.
// RULE_04: Program address and data go on the fourth cycle.
// RULE_05: Erase repeats unlock on four and five, confirm on six.
// RULE_06: Device resets its command interface to read on power-up or low supply.
// RULE_07: Array holds eleven blocks: boot, two parameter, one 32 KB, seven 64 KB.
// RULE_08: Top-boot block selection by address bits 17..12.
// RULE_09: Bottom-boot block selection by address bits 17..12.
// RULE_10: Block erase may be suspended and later resumed.
// RULE_11: Device latches the address on the falling strobe edge.
// RULE_12: Device latches commands and data on the rising strobe edge.
// RULE_13: Width select low gives byte mode with top data pin as address LSB.
// RULE_14: In word mode only the low byte counts for commands and status.
// RULE_15: Status bits: poll 7, toggles 6 and 2, error 5, erase timer 3.
// RULE_16: Device drives data only while chip and output enables are active.
// RULE_17: Ready/busy low while busy; only suspend accepted then.
// RULE_18: Ready/busy high when idle, suspended or in standby.
// RULE_19: Host holds reset low at least 500 ns.
// RULE_20: After reset in read mode the device is ready 50 ns after release.
// RULE_21: Reset during program or erase takes 10 us, ready/busy marks the end.
// RULE_22: High-voltage level on reset unprotects blocks while held.
// RULE_23: Host writes with chip and write enables low, output enable high.
// RULE_24: Host reads with chip and output enables both low.
// RULE_25: After hardware reset the command interface is in array read.
`timescale 1ns/1ns
`include "bbfh_params.svh"
module bbfh_host
	import bbfh_pkg::*;
#(
	parameter int RST_LOW_CYC   = `BBFH_RST_LOW_CYC,
	parameter int RST_READY_CYC = `BBFH_RST_READY_CYC,
	parameter int RST_BUSY_CYC  = `BBFH_RST_BUSY_CYC,
	parameter int STROBE_CYC    = `BBFH_STROBE_CYC
) (
	// Clock and reset.
	input  wire logic                    i_clk,
	input  wire logic                    i_rst,
	// User request side.
	input  wire logic                    i_req_valid,
	input  wire bbfh_req_t               i_req,
	input  wire logic                    i_byte_mode,
	input  wire logic                    i_unprotect,
	output logic                         o_req_ready,
	output logic                         o_rsp_valid,
	output logic [`BBFH_DATA_W-1:0]      o_rsp_data,
	output bbfh_stat_t                   o_status,
	output logic                         o_refused,
	output logic                         o_dev_busy,
	// Device pins.
	output logic                         o_ce_n,
	output logic                         o_we_n,
	output logic                         o_oe_n,
	output logic [`BBFH_ADDR_W-1:0]      o_addr,
	output logic [`BBFH_DATA_W-1:0]      o_dq,
	output logic [`BBFH_DATA_W-1:0]      o_dq_oe_n,
	input  wire logic [`BBFH_DATA_W-1:0] i_dq,
	output logic                         o_byte_n,
	output logic                         o_reset_unprotect_n,
	output logic                         o_high_voltage_level,
	input  wire logic                    i_ready_busy_n
);

	typedef enum logic [2:0] {H_IDLE, H_ISSUE, H_WAIT, H_RST_LOW, H_RST_REL, H_RESP} bbfh_hst_t;

	bbfh_hst_t         st_reg, st_next;
	bbfh_req_t         req_reg, req_next;
	logic [2:0]        idx_reg, idx_next, last_reg, last_next;
	logic [15:0]       tcnt_reg, tcnt_next;
	logic              rdy_reg, rdy_next, rsp_reg, rsp_next, ref_reg, ref_next, rstn_reg, rstn_next;
	logic [15:0]       rdat_reg, rdat_next;
	logic              byte_n_reg, hv_reg, busy_reg;
	logic              rb1_reg, rb2_reg;
	logic              start, done;
	bbfh_cyc_t         cyc;
	logic [15:0]       rdata;

	// Ready/busy is a pin: two flops before use.
	always_ff @(posedge i_clk) begin
		rb1_reg <= i_ready_busy_n;
		rb2_reg <= rb1_reg;
	end

	// Pick the bus cycle for the current step of the sequence.
	always_comb begin
		cyc = '0;
		cyc.is_write = 1'b1;
		cyc.addr_lsb = req_reg.addr_lsb;
		case (idx_reg)
			3'd0, 3'd3: begin
				cyc.addr = `BBFH_UNLOCK_A1; // RULE_02
				cyc.data = {8'h00, `BBFH_UNLOCK_D1}; // RULE_14
			end
			3'd1, 3'd4: begin
				cyc.addr = `BBFH_UNLOCK_A2; // RULE_02
				cyc.data = {8'h00, `BBFH_UNLOCK_D2};
			end
			3'd2: begin
				cyc.addr = `BBFH_UNLOCK_A1;
				case (req_reg.op)
					BBFH_OP_PROGRAM: cyc.data = {8'h00, `BBFH_CMD_PROGRAM};
					BBFH_OP_BLK_ERASE, BBFH_OP_CHIP_ERASE: cyc.data = {8'h00, `BBFH_CMD_ERASE_SETUP};
					default: cyc.data = {8'h00, `BBFH_CMD_READ};
				endcase
			end
			3'd5: begin
				// Block erase confirms at the block address, chip erase at the unlock address.
				cyc.addr = (req_reg.op == BBFH_OP_BLK_ERASE) ? req_reg.addr : `BBFH_UNLOCK_A1; // RULE_05
				cyc.data = {8'h00, (req_reg.op == BBFH_OP_BLK_ERASE) ? `BBFH_CMD_BLK_ERASE : `BBFH_CMD_CHIP_ERASE};
			end
			default: cyc = '0;
		endcase
		// Single-cycle operations: a read, or suspend/resume/reset written to the request address.
		if (last_reg == 3'd0) begin
			cyc.addr = req_reg.addr;
			cyc.is_write = (req_reg.op != BBFH_OP_READ); // RULE_24
			case (req_reg.op)
				BBFH_OP_SUSPEND: cyc.data = {8'h00, `BBFH_CMD_SUSPEND}; // RULE_10
				BBFH_OP_RESUME: cyc.data = {8'h00, `BBFH_CMD_RESUME};
				default: cyc.data = {8'h00, `BBFH_CMD_READ}; // RULE_03
			endcase
		end else if (req_reg.op == BBFH_OP_PROGRAM && idx_reg == 3'd3) begin
			cyc.addr = req_reg.addr; // RULE_04
			cyc.data = req_reg.data;
		end
	end

	assign start = (st_reg == H_ISSUE);

	// Sequencer: one request at a time, walking its bus cycles.
	always_comb begin
		st_next = st_reg;
		req_next = req_reg;
		idx_next = idx_reg;
		last_next = last_reg;
		tcnt_next = tcnt_reg;
		rdy_next = 1'b0;
		rsp_next = 1'b0;
		ref_next = 1'b0;
		rdat_next = rdat_reg;
		rstn_next = rstn_reg;
		case (st_reg)
			H_IDLE: begin
				rdy_next = 1'b1;
				if (i_req_valid && rdy_reg) begin
					rdy_next = 1'b0;
					req_next = i_req;
					idx_next = 3'd0;
					// Busy device takes only suspend, reads, the reset command or a hardware reset.
					if (i_req.op == BBFH_OP_HW_RESET) begin
						rstn_next = 1'b0; // RULE_19
						tcnt_next = 16'h0000;
						st_next = H_RST_LOW;
					end else if (!rb2_reg && (i_req.op == BBFH_OP_PROGRAM || i_req.op == BBFH_OP_BLK_ERASE ||
							i_req.op == BBFH_OP_CHIP_ERASE || i_req.op == BBFH_OP_RESUME)) begin
						ref_next = 1'b1; // RULE_17
						rdy_next = 1'b1;
					end else begin
						case (i_req.op)
							BBFH_OP_PROGRAM: last_next = 3'd3; // RULE_01
							BBFH_OP_BLK_ERASE, BBFH_OP_CHIP_ERASE: last_next = 3'd5; // RULE_01
							default: last_next = 3'd0;
						endcase
						st_next = H_ISSUE;
					end
				end
			end
			H_ISSUE: st_next = H_WAIT;
			H_WAIT: begin
				if (done) begin
					rdat_next = rdata;
					if (idx_reg == last_reg) begin
						st_next = H_RESP;
					end else begin
						idx_next = idx_reg + 3'd1;
						st_next = H_ISSUE;
					end
				end
			end
			H_RST_LOW: begin
				tcnt_next = tcnt_reg + 16'h0001;
				if (tcnt_reg == 16'(RST_LOW_CYC - 1)) begin
					rstn_next = 1'b1;
					tcnt_next = 16'h0000;
					st_next = H_RST_REL;
				end
			end
			H_RST_REL: begin
				// Wait the short recovery, then keep waiting while ready/busy is low, bounded by the long one.
				tcnt_next = tcnt_reg + 16'h0001;
				if ((tcnt_reg >= 16'(RST_READY_CYC) && rb2_reg) ||
						tcnt_reg == 16'(RST_BUSY_CYC + RST_READY_CYC)) begin // RULE_20 RULE_21
					st_next = H_RESP; // RULE_25
				end
			end
			H_RESP: begin
				rsp_next = 1'b1;
				rdy_next = 1'b1;
				st_next = H_IDLE;
			end
			default: st_next = H_IDLE;
		endcase
	end

	// Sequencer registers; byte mode and unprotect are sampled only between requests.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_reg <= H_IDLE;
			req_reg <= '0;
			idx_reg <= 3'd0;
			last_reg <= 3'd0;
			tcnt_reg <= 16'h0000;
			rdy_reg <= 1'b0;
			rsp_reg <= 1'b0;
			ref_reg <= 1'b0;
			rdat_reg <= '0;
			rstn_reg <= 1'b1;
			byte_n_reg <= 1'b1;
			hv_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			req_reg <= req_next;
			idx_reg <= idx_next;
			last_reg <= last_next;
			tcnt_reg <= tcnt_next;
			rdy_reg <= rdy_next;
			rsp_reg <= rsp_next;
			ref_reg <= ref_next;
			rdat_reg <= rdat_next;
			rstn_reg <= rstn_next;
			busy_reg <= ~rb2_reg; // RULE_18
			if (st_reg == H_IDLE) begin
				byte_n_reg <= ~i_byte_mode; // RULE_13
				hv_reg <= i_unprotect && rstn_next; // RULE_22
			end
		end
	end

	bbfh_strobe #(
		.STROBE_CYC (STROBE_CYC)
	) u_strobe (
		.i_clk       (i_clk),
		.i_rst       (i_rst),
		.i_start     (start),
		.i_cyc       (cyc),
		.i_byte_mode (~byte_n_reg),
		.o_done      (done),
		.o_rdata     (rdata),
		.o_ce_n      (o_ce_n),
		.o_we_n      (o_we_n),
		.o_oe_n      (o_oe_n),
		.o_addr      (o_addr),
		.o_dq        (o_dq),
		.o_dq_oe_n   (o_dq_oe_n),
		.i_dq        (i_dq)
	);

	// Status view of the data sampled on the last bus cycle, read or write, low byte only.
	assign o_status.poll = rdat_reg[`BBFH_BIT_POLL]; // RULE_15
	assign o_status.toggle = rdat_reg[`BBFH_BIT_TOGGLE];
	assign o_status.error = rdat_reg[`BBFH_BIT_ERROR];
	assign o_status.erase_timer = rdat_reg[`BBFH_BIT_ETIMER];
	assign o_status.toggle2 = rdat_reg[`BBFH_BIT_TOGGLE2];
	assign o_req_ready = rdy_reg;
	assign o_rsp_valid = rsp_reg;
	assign o_rsp_data = rdat_reg;
	assign o_refused = ref_reg;
	assign o_dev_busy = busy_reg;
	assign o_byte_n = byte_n_reg;
	// High-voltage request only while reset is released.
	assign o_reset_unprotect_n = rstn_reg;
	assign o_high_voltage_level = hv_reg;

endmodule

/* bench/bbfh_host_checker.sv */
// Concurrent checks on the pins of the boot-block flash host.
// Assumes it is bound into bbfh_host and sees only that module's ports.
`timescale 1ns/1ns
`include "bbfh_params.svh"
module bbfh_host_checker #(
	parameter int RST_LOW_CYC = `BBFH_RST_LOW_CYC
) (
	input wire logic                    i_clk,
	input wire logic                    i_rst,
	input wire logic                    o_ce_n,
	input wire logic                    o_we_n,
	input wire logic                    o_oe_n,
	input wire logic [`BBFH_ADDR_W-1:0] o_addr,
	input wire logic [`BBFH_DATA_W-1:0] o_dq,
	input wire logic [`BBFH_DATA_W-1:0] o_dq_oe_n,
	input wire logic                    o_byte_n,
	input wire logic                    o_reset_unprotect_n,
	input wire logic                    o_high_voltage_level,
	input wire logic                    i_ready_busy_n,
	input wire logic                    o_refused,
	input wire logic                    o_dev_busy
);
	int low_cnt;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	// Counts consecutive low samples of the reset pin so the pulse width can be judged on release.
	always_ff @(posedge i_clk) begin
		if (i_rst || o_reset_unprotect_n) begin
			low_cnt <= 0;
		end else begin
			low_cnt <= low_cnt + 1;
		end
	end

	AST_WRITE_OE: assert property (!o_we_n |-> !o_ce_n && o_oe_n)
		else $error("write strobe without chip enable or with output enable");
	AST_READ_CE: assert property (!o_oe_n |-> !o_ce_n && o_we_n)
		else $error("output enable without chip enable or with write enable");
	AST_WRITE_DRIVES: assert property (!o_we_n |-> o_dq_oe_n[7:0] == 8'h00)
		else $error("low data byte not driven during write");
	AST_READ_RELEASES: assert property (!o_oe_n |-> o_dq_oe_n[14:0] == 15'h7fff && (o_dq_oe_n[15] || !o_byte_n))
		else $error("host drives data pins during a read");
	AST_STROBE_STABLE: assert property ((!o_we_n && !$past(o_we_n)) |-> $stable(o_addr) && $stable(o_dq[7:0]))
		else $error("address or data moved while write strobe low");
	AST_BYTE_FLOAT: assert property ((!o_we_n && !o_byte_n) |-> o_dq_oe_n[14:8] == 7'h7f && !o_dq_oe_n[15])
		else $error("byte mode write pin drive wrong");
	AST_RST_LOW: assert property ((o_reset_unprotect_n && low_cnt != 0) |-> low_cnt >= RST_LOW_CYC)
		else $error("reset pulse too short");
	AST_RST_QUIET: assert property (!o_reset_unprotect_n |-> o_ce_n && o_we_n && o_oe_n)
		else $error("bus strobed while reset pin low");
	AST_REFUSE_BUSY: assert property (o_refused |-> o_dev_busy || $past(o_dev_busy))
		else $error("request refused while device ready");
	AST_BUSY_TRACK: assert property ((!i_ready_busy_n)[*5] |-> o_dev_busy)
		else $error("busy not reported");
	AST_IDLE_TRACK: assert property (i_ready_busy_n[*5] |-> !o_dev_busy)
		else $error("busy reported while ready");
	AST_HV_LEVEL: assert property (o_high_voltage_level |-> o_reset_unprotect_n)
		else $error("high voltage requested while reset pin low");
endmodule

bind bbfh_host bbfh_host_checker #(.RST_LOW_CYC(RST_LOW_CYC)) chk_i (.i_clk(i_clk), .i_rst(i_rst),
	.o_ce_n(o_ce_n), .o_we_n(o_we_n), .o_oe_n(o_oe_n), .o_addr(o_addr), .o_dq(o_dq), .o_dq_oe_n(o_dq_oe_n),
	.o_byte_n(o_byte_n), .o_reset_unprotect_n(o_reset_unprotect_n), .o_high_voltage_level(o_high_voltage_level),
	.i_ready_busy_n(i_ready_busy_n), .o_refused(o_refused), .o_dev_busy(o_dev_busy));

/* bench/bbfh_flash_model.sv */
// Behavioural flash device: command decoder, busy timer, read data and data bus resolution.
// Assumes host pins change on clock edges, so strobe edges are detected on the bench clock.
`timescale 1ns/1ns
module bbfh_flash_model #(
	parameter int PROG_CYC  = 60,
	parameter int ERASE_CYC = 200,
	parameter int RST_CYC   = 20
) (
	input  wire logic        i_clk,
	input  wire logic        i_ce_n,
	input  wire logic        i_we_n,
	input  wire logic        i_oe_n,
	input  wire logic [17:0] i_addr,
	input  wire logic [15:0] i_dq,
	input  wire logic [15:0] i_dq_oe_n,
	input  wire logic        i_byte_n,
	input  wire logic        i_rst_pin_n,
	output logic [15:0]      o_bus,
	output logic             o_ready_busy_n,
	output int               o_n_prog,
	output int               o_n_erase,
	output logic [18:0]      o_prog_addr,
	output logic [15:0]      o_prog_data,
	output logic [7:0]       o_erase_cmd
);
	logic        strb_q = 1'b1;
	logic [17:0] a_lat;
	logic        lsb_lat;
	logic [2:0]  step = 3'h0;
	logic        is_erase = 1'b0;
	logic        susp = 1'b0;
	int          busy_cnt = 0;
	logic [15:0] dev_dq;
	logic [15:0] last = 16'h0000;
	logic [15:0] word;
	logic [15:0] mem [logic [17:0]];
	logic        dev_oe;
	wire         strb = i_ce_n | i_we_n;
	wire  [7:0]  cmd = o_bus[7:0];

	initial begin
		o_n_prog = 0;
		o_n_erase = 0;
	end
	assign o_ready_busy_n = (busy_cnt == 0) || susp;
	assign dev_oe = !i_ce_n && !i_oe_n && i_rst_pin_n;

	// Read data: status while busy, otherwise the array word or the addressed byte of it.
	always_comb begin
		word = mem.exists(i_addr) ? mem[i_addr] : i_addr[15:0] ^ 16'h3c3c;
		if (busy_cnt > 0 && !susp) begin
			dev_dq = {8'h00, ~o_prog_data[7], 7'h00};
		end else if (!i_byte_n) begin
			dev_dq = i_dq[15] ? {8'h00, word[15:8]} : {8'h00, word[7:0]};
		end else begin
			dev_dq = word;
		end
		// Undriven bits show the inverse of their last level so a stale value never looks valid.
		for (int i = 0; i < 16; i++) begin
			if (!i_dq_oe_n[i]) o_bus[i] = i_dq[i];
			else if (dev_oe && (i_byte_n || i < 8)) o_bus[i] = dev_dq[i];
			else o_bus[i] = ~last[i];
		end
	end

	// Command interface and busy timer.
	always @(posedge i_clk) begin
		strb_q <= strb;
		last <= o_bus;
		if (busy_cnt > 0 && !susp) busy_cnt <= busy_cnt - 1;
		if (!i_rst_pin_n) begin
			step <= 3'h0;
			susp <= 1'b0;
			if (busy_cnt > 0) busy_cnt <= RST_CYC;
		end else if (strb_q && !strb) begin
			a_lat <= i_addr;
			lsb_lat <= i_byte_n ? 1'b0 : i_dq[15];
		end else if (!strb_q && strb) begin
			if (busy_cnt > 0 && !susp) begin
				if (cmd == 8'hb0 && is_erase) susp <= 1'b1;
				step <= 3'h0;
			end else begin
				case (step)
					3'h0: begin
						if (susp && cmd == 8'h30) susp <= 1'b0;
						step <= (cmd == 8'haa && a_lat == 18'h05555) ? 3'h1 : 3'h0;
					end
					3'h1: step <= (cmd == 8'h55 && a_lat == 18'h02aaa) ? 3'h2 : 3'h0;
					3'h2: step <= cmd == 8'ha0 ? 3'h3 : (cmd == 8'h80 ? 3'h4 : 3'h0);
					3'h3: begin
						o_n_prog <= o_n_prog + 1;
						o_prog_addr <= {a_lat, lsb_lat};
						o_prog_data <= i_byte_n ? o_bus : {8'h00, o_bus[7:0]};
						if (i_byte_n) mem[a_lat] = o_bus;
						busy_cnt <= PROG_CYC;
						is_erase <= 1'b0;
						step <= 3'h0;
					end
					3'h4: step <= (cmd == 8'haa && a_lat == 18'h05555) ? 3'h5 : 3'h0;
					3'h5: step <= (cmd == 8'h55 && a_lat == 18'h02aaa) ? 3'h6 : 3'h0;
					default: begin
						if (cmd == 8'h30 || cmd == 8'h10) begin
							o_n_erase <= o_n_erase + 1;
							o_erase_cmd <= cmd;
							busy_cnt <= ERASE_CYC;
							is_erase <= 1'b1;
						end
						step <= 3'h0;
					end
				endcase
			end
		end
	end
endmodule

/* bench/tb.sv */
// Self-checking bench: drives user requests into the host and checks the flash model's view.
// Assumes the behavioural flash model and the bound pin checker.
`timescale 1ns/1ns
module tb;
	import bbfh_pkg::*;
	logic        clk, rst, req_valid, byte_mode, unprotect, ref_seen;
	bbfh_req_t   req;
	logic        req_ready, rsp_valid, refused, dev_busy, ce_n, we_n, oe_n, byte_n, rst_pin_n, hv, rbn;
	logic [15:0] rsp_data, dq, dq_oe_n, bus, got, p_data;
	logic [17:0] addr;
	logic [18:0] p_addr;
	logic [7:0]  e_cmd;
	bbfh_stat_t  status;
	int          n_prog, n_erase, err_count, n_checks, op_cyc;

	bbfh_host #(.RST_BUSY_CYC(40)) uut (.i_clk(clk), .i_rst(rst), .i_req_valid(req_valid), .i_req(req),
		.i_byte_mode(byte_mode), .i_unprotect(unprotect), .o_req_ready(req_ready), .o_rsp_valid(rsp_valid),
		.o_rsp_data(rsp_data), .o_status(status), .o_refused(refused), .o_dev_busy(dev_busy), .o_ce_n(ce_n),
		.o_we_n(we_n), .o_oe_n(oe_n), .o_addr(addr), .o_dq(dq), .o_dq_oe_n(dq_oe_n), .i_dq(bus),
		.o_byte_n(byte_n), .o_reset_unprotect_n(rst_pin_n), .o_high_voltage_level(hv), .i_ready_busy_n(rbn));
	bbfh_flash_model dev (.i_clk(clk), .i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n), .i_addr(addr), .i_dq(dq),
		.i_dq_oe_n(dq_oe_n), .i_byte_n(byte_n), .i_rst_pin_n(rst_pin_n), .o_bus(bus), .o_ready_busy_n(rbn),
		.o_n_prog(n_prog), .o_n_erase(n_erase), .o_prog_addr(p_addr), .o_prog_data(p_data), .o_erase_cmd(e_cmd));

	// Free-running 100 MHz clock.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Prints the verdict and ends the run.
	task automatic results;
		if (err_count == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// Compares one value and counts it.
	task automatic chk(input string what, input logic [18:0] exp, input logic [18:0] act);
		n_checks++;
		if (act !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, act);
		end
	endtask

	// Issues one request and waits for its answer or its refusal.
	task automatic op(input bbfh_op_t o, input logic [17:0] a, input logic l, input logic [15:0] d);
		int t;
		t = 0;
		while (req_ready !== 1'b1 && t < 2000) begin
			@(posedge clk); #1;
			t++;
		end
		req = '{o, a, l, d};
		req_valid = 1'b1;
		@(posedge clk); #1;
		req_valid = 1'b0;
		ref_seen = (refused === 1'b1);
		op_cyc = 0;
		while (rsp_valid !== 1'b1 && !ref_seen && op_cyc < 3000) begin
			@(posedge clk); #1;
			ref_seen = (refused === 1'b1);
			op_cyc++;
		end
		got = rsp_data;
		if (t >= 2000 || op_cyc >= 3000) err_count++;
	endtask

	// Waits for the device to finish; the first cycles cover the busy synchroniser lag.
	task automatic wait_idle;
		int t;
		t = 0;
		repeat (6) @(posedge clk);
		#1;
		while (dev_busy !== 1'b0 && t < 1000) begin
			@(posedge clk); #1;
			t++;
		end
		if (t >= 1000) err_count++;
	endtask

	// Hang guard, well beyond the expected run of about a thousand cycles.
	initial begin
		#300000;
		err_count++;
		results;
	end

	// Main sequence.
	initial begin
		err_count = 0;
		n_checks = 0;
		rst = 1'b1;
		req_valid = 1'b0;
		req = '0;
		byte_mode = 1'b0;
		unprotect = 1'b0;
		repeat (4) @(posedge clk);
		#1 rst = 1'b0;
		@(posedge clk); #1;
		chk("req_ready", 19'h1, {18'h0, req_ready});
		op(BBFH_OP_READ, 18'h01234, 1'b0, 16'h0000);
		chk("read", {3'h0, 16'h1234 ^ 16'h3c3c}, {3'h0, got});
		unprotect = 1'b1;
		op(BBFH_OP_PROGRAM, 18'h3e010, 1'b0, 16'ha55a);
		unprotect = 1'b0;
		chk("prog_count", 19'h1, n_prog[18:0]);
		chk("prog_addr", {18'h3e010, 1'b0}, p_addr);
		chk("prog_data", {3'h0, 16'ha55a}, {3'h0, p_data});
		op(BBFH_OP_READ, 18'h3e010, 1'b0, 16'h0000);
		chk("status_poll", 19'h1, {18'h0, status.poll});
		op(BBFH_OP_PROGRAM, 18'h00010, 1'b0, 16'h1111);
		chk("refused", 19'h1, {18'h0, ref_seen});
		chk("prog_count_busy", 19'h1, n_prog[18:0]);
		wait_idle;
		op(BBFH_OP_READ, 18'h3e010, 1'b0, 16'h0000);
		chk("readback", {3'h0, 16'ha55a}, {3'h0, got});
		op(BBFH_OP_BLK_ERASE, 18'h04000, 1'b0, 16'h0000);
		chk("erase_count", 19'h1, n_erase[18:0]);
		chk("erase_cmd", 19'h30, {11'h0, e_cmd});
		op(BBFH_OP_SUSPEND, 18'h04000, 1'b0, 16'h0000);
		repeat (6) @(posedge clk);
		#1;
		chk("suspended_ready", 19'h0, {18'h0, dev_busy});
		op(BBFH_OP_READ, 18'h00100, 1'b0, 16'h0000);
		chk("suspend_read", {3'h0, 16'h0100 ^ 16'h3c3c}, {3'h0, got});
		op(BBFH_OP_RESUME, 18'h04000, 1'b0, 16'h0000);
		repeat (6) @(posedge clk);
		#1;
		chk("resumed_busy", 19'h1, {18'h0, dev_busy});
		wait_idle;
		op(BBFH_OP_CHIP_ERASE, 18'h00000, 1'b0, 16'h0000);
		chk("chip_erase_cmd", 19'h10, {11'h0, e_cmd});
		wait_idle;
		op(BBFH_OP_RESET_CMD, 18'h00000, 1'b0, 16'h0000);
		chk("erase_count_reset", 19'h2, n_erase[18:0]);
		op(BBFH_OP_PROGRAM, 18'h00020, 1'b0, 16'h0f0f);
		op(BBFH_OP_HW_RESET, 18'h00000, 1'b0, 16'h0000);
		chk("reset_span", 19'h1, {18'h0, op_cyc >= 70});
		op(BBFH_OP_PROGRAM, 18'h00030, 1'b0, 16'h1234);
		chk("prog_after_reset", 19'h3, n_prog[18:0]);
		wait_idle;
		byte_mode = 1'b1;
		op(BBFH_OP_PROGRAM, 18'h00200, 1'b1, 16'h00c3);
		chk("byte_prog_addr", {18'h00200, 1'b1}, p_addr);
		chk("byte_prog_data", 19'hc3, {3'h0, p_data});
		wait_idle;
		op(BBFH_OP_READ, 18'h00200, 1'b1, 16'h0000);
		chk("byte_read", 19'h3e, {11'h0, got[7:0]});
		byte_mode = 1'b0;
		results;
	end
endmodule
